// file: design/scl_loader.v
/*
 * Configuration loader: fetches the bitstream from an SPI flash (active),
 * a slave port (passive), the test port or the mask memory, and writes it
 * into configuration cell memory, then signals done.
 * Assumes mclk at 250 MHz; all pins come from outside the clock domain.
 */
`default_nettype none
`include "scl_consts.vh"
//
// Functional notes
// - Write bitstream to cell memory before operation
// - Active x1/2/4, passive up to x8, JTAG x1
// - Active mode makes serial clock internally
// - Device drives instruction and address bytes
// - First transaction is flash wake-up
// - Wait at least 30 us after wake
// - Fast read from address zero, sequential
// - Test port delivers bitstream in JTAG mode
// - Mask option loads from on-chip memory
// - GPIOs weak pull-up while configuring
module scl_loader #(
    parameter WAKE_CYC   = `SCL_WAKE_CYC,
    parameter LOAD_BYTES = `SCL_CFG_DEPTH
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Configuration control pins
    input  wire        config_reset_n,
    input  wire [1:0]  cfg_mode,
    input  wire [1:0]  cfg_width,
    input  wire        mask_memory_option,
    output reg         cfg_done,
    output reg         user_mode,
    output reg         gpio_weak_pullup,
    // Active SPI master
    output reg         spi_sck,
    output reg         spi_cs_n,
    output reg  [3:0]  spi_dq_out,
    output reg  [3:0]  spi_dq_oe,
    input  wire [3:0]  spi_dq_in,
    // Passive slave and test port
    input  wire        pas_clk,
    input  wire        pas_cs_n,
    input  wire [7:0]  pas_data,
    input  wire        tck,
    input  wire        tdi,
    input  wire        jtag_load_en,
    // Mask memory read port
    output reg  [7:0]  mask_addr,
    input  wire [7:0]  mask_data,
    // Configuration cell memory write port
    output reg         cfg_we,
    output reg  [7:0]  cfg_addr,
    output reg  [7:0]  cfg_wdata
);
    // States, one-hot
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_WAKE = 7'h02;
    localparam [6:0] S_WAIT = 7'h04;
    localparam [6:0] S_HDR  = 7'h08;
    localparam [6:0] S_DATA = 7'h10;
    localparam [6:0] S_SLV  = 7'h20;
    localparam [6:0] S_DONE = 7'h40;

    // Lanes per serial clock for a width code; the caller applies the mode caps
    function [3:0] lanes;
        input [1:0] w;
        begin
            case (w)
                `SCL_W_X1: lanes = 4'h1;
                `SCL_W_X2: lanes = 4'h2;
                `SCL_W_X4: lanes = 4'h4;
                default:   lanes = 4'h8;
            endcase
        end
    endfunction

    // Two-flop synchronisers for all pin inputs except mask_memory_option
    reg [16:0] s1_r;
    reg [16:0] s2_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 17'h0_0000;
            s2_r <= 17'h0_0000;
        end else begin
            s1_r <= {config_reset_n, pas_clk, pas_cs_n, tck, tdi, jtag_load_en,
                     spi_dq_in, pas_data[6:0]};
            s2_r <= s1_r;
        end
    end
    reg [4:0] s1b_r;
    reg [4:0] s2b_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1b_r <= 5'h00;
            s2b_r <= 5'h00;
        end else begin
            s1b_r <= {pas_data[7], cfg_mode, cfg_width};
            s2b_r <= s1b_r;
        end
    end
    wire       creset_s = s2_r[16];
    wire       pclk_s   = s2_r[15];
    wire       pcs_s    = s2_r[14];
    wire       tck_s    = s2_r[13];
    wire       tdi_s    = s2_r[12];
    wire       jen_s    = s2_r[11];
    wire [3:0] dq_s     = s2_r[10:7];
    wire [7:0] pdat_s   = {s2b_r[4], s2_r[6:0]};
    wire [1:0] mode_s   = s2b_r[3:2];
    wire [1:0] width_s  = s2b_r[1:0];

    // Edge detect on synchronised external clocks and config reset
    reg pclk_d_r;
    reg tck_d_r;
    reg creset_d_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_d_r   <= 1'b0;
            tck_d_r    <= 1'b0;
            creset_d_r <= 1'b0;
        end else begin
            pclk_d_r   <= pclk_s;
            tck_d_r    <= tck_s;
            creset_d_r <= creset_s;
        end
    end
    wire pclk_rise = pclk_s & ~pclk_d_r;
    wire tck_rise  = tck_s & ~tck_d_r;
    wire start     = creset_s & ~creset_d_r;

    // FIFO between source and cell memory
    reg        f_in_valid_r;
    reg  [7:0] f_in_data_r;
    wire       f_in_ready;
    wire       f_out_valid;
    wire [7:0] f_out_data;
    scl_fifo #(
        .WIDTH (`SCL_FIFO_W),
        .DEPTH (`SCL_FIFO_D),
        .AW    (`SCL_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (f_in_valid_r),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data_r),
        .out_valid (f_out_valid),
        .out_ready (1'b1),
        .out_data  (f_out_data)
    );

    // Serial clock divider enable
    reg [3:0] div_r;
    wire      half_tick = (div_r == `SCL_SCK_HALF - 4'h1);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 4'h0;
        end else begin
            div_r <= half_tick ? 4'h0 : div_r + 4'h1;
        end
    end

    // Main sequencer
    reg [6:0]  state_r;
    reg [1:0]  mode_r;
    reg [3:0]  nl_r;
    reg [39:0] sh_r;
    reg [5:0]  bits_r;
    reg [15:0] wait_r;
    reg [8:0]  got_r;
    reg [7:0]  rx_r;
    reg [3:0]  rx_n_r;
    reg [8:0]  wr_n_r;
    wire       shift_ok = f_in_ready | ~f_in_valid_r;
    wire       sck_fall = half_tick & spi_sck;
    wire       sck_rise = half_tick & ~spi_sck;
    wire [3:0] rx_step  = rx_n_r + nl_r;
    // Opening words of each frame; the first bit is set up before sck rises
    wire [7:0]  wake_cmd = `SCL_CMD_WAKE;
    wire [39:0] hdr_word = {`SCL_CMD_FREAD, `SCL_START_ADDR, 8'h00};

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r          <= S_IDLE;
            mode_r           <= `SCL_MODE_ACTIVE;
            nl_r             <= 4'h1;
            sh_r             <= 40'h00_0000_0000;
            bits_r           <= 6'h00;
            wait_r           <= 16'h0000;
            got_r            <= 9'h000;
            rx_r             <= 8'h00;
            rx_n_r           <= 4'h0;
            f_in_valid_r     <= 1'b0;
            f_in_data_r      <= 8'h00;
            spi_sck          <= 1'b0;
            spi_cs_n         <= 1'b1;
            spi_dq_out       <= 4'h0;
            spi_dq_oe        <= 4'h0;
            mask_addr        <= 8'h00;
            gpio_weak_pullup <= 1'b1;
        end else begin
            if (f_in_valid_r && f_in_ready) begin
                f_in_valid_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    gpio_weak_pullup <= 1'b1;
                    if (start) begin
                        mode_r <= mask_memory_option ? `SCL_MODE_MASK : mode_s;
                        // Active capped at x4, JTAG forced x1
                        if (mode_s == `SCL_MODE_JTAG || mask_memory_option) begin
                            nl_r <= 4'h1;
                        end else if (mode_s == `SCL_MODE_ACTIVE &&
                                     width_s == `SCL_W_X8) begin
                            nl_r <= 4'h4;
                        end else begin
                            nl_r <= lanes(width_s);
                        end
                        got_r  <= 9'h000;
                        rx_n_r <= 4'h0;
                        if (!mask_memory_option && mode_s == `SCL_MODE_ACTIVE) begin
                            sh_r       <= {wake_cmd[6:0], 33'h0_0000_0000};
                            spi_dq_out <= {3'h0, wake_cmd[7]};
                            bits_r    <= `SCL_WAKE_BITS;
                            spi_cs_n  <= 1'b0;
                            spi_dq_oe <= 4'h1;
                            state_r   <= S_WAKE;
                        end else begin
                            mask_addr <= 8'h00;
                            state_r   <= S_SLV;
                        end
                    end
                end
                S_WAKE, S_HDR: begin
                    // Command bits go out on DQ0, changed on falling sck
                    if (half_tick) begin
                        spi_sck <= ~spi_sck;
                    end
                    if (sck_fall) begin
                        spi_dq_out <= {3'h0, sh_r[39]};
                        sh_r       <= {sh_r[38:0], 1'b0};
                    end
                    if (sck_fall) begin
                        bits_r <= bits_r - 6'h01;
                        if (bits_r == 6'h01) begin
                            spi_sck <= 1'b0;
                            if (state_r == S_WAKE) begin
                                spi_cs_n  <= 1'b1;
                                spi_dq_oe <= 4'h0;
                                wait_r    <= WAKE_CYC[15:0];
                                state_r   <= S_WAIT;
                            end else begin
                                spi_dq_oe <= 4'h0;
                                bits_r    <= 6'h08;  // Dummy byte cycles
                                state_r   <= S_DATA;
                            end
                        end
                    end
                end
                S_WAIT: begin
                    if (wait_r != 16'h0000) begin
                        wait_r <= wait_r - 16'h0001;
                    end else begin
                        sh_r       <= {hdr_word[38:0], 1'b0};
                        spi_dq_out <= {3'h0, hdr_word[39]};
                        bits_r    <= `SCL_HDR_BITS;
                        spi_cs_n  <= 1'b0;
                        spi_dq_oe <= 4'h1;
                        state_r   <= S_HDR;
                    end
                end
                S_DATA: begin
                    // Sck pauses while the FIFO cannot take a byte
                    if (half_tick && (shift_ok || spi_sck)) begin
                        spi_sck <= ~spi_sck;
                    end
                    // Frame ends on a falling sck so the high phase stays whole
                    if (sck_fall && got_r == LOAD_BYTES[8:0]) begin
                        spi_cs_n <= 1'b1;
                        state_r  <= S_DONE;
                    end
                    if (sck_rise && shift_ok && got_r != LOAD_BYTES[8:0]) begin
                        if (bits_r != 6'h00) begin
                            bits_r <= bits_r - 6'h01;  // Dummy cycles
                        end else begin
                            rx_r   <= (nl_r == 4'h1) ? {rx_r[6:0], dq_s[0]} :
                                      (nl_r == 4'h2) ? {rx_r[5:0], dq_s[1:0]} :
                                      {rx_r[3:0], dq_s};
                            rx_n_r <= (rx_step == 4'h8) ? 4'h0 : rx_step;
                            if (rx_step == 4'h8) begin
                                f_in_valid_r <= 1'b1;
                                f_in_data_r  <= (nl_r == 4'h1) ? {rx_r[6:0], dq_s[0]} :
                                                (nl_r == 4'h2) ? {rx_r[5:0], dq_s[1:0]} :
                                                {rx_r[3:0], dq_s};
                                got_r <= got_r + 9'h001;
                            end
                        end
                    end
                end
                S_SLV: begin
                    if (shift_ok && got_r != LOAD_BYTES[8:0]) begin
                        if (mode_r == `SCL_MODE_MASK) begin
                            f_in_valid_r <= 1'b1;
                            f_in_data_r  <= mask_data;
                            mask_addr    <= mask_addr + 8'h01;
                            got_r        <= got_r + 9'h001;
                        end else if (mode_r == `SCL_MODE_JTAG) begin
                            if (tck_rise && jen_s) begin
                                rx_r   <= {rx_r[6:0], tdi_s};
                                rx_n_r <= (rx_n_r == 4'h7) ? 4'h0 : rx_n_r + 4'h1;
                                if (rx_n_r == 4'h7) begin
                                    f_in_valid_r <= 1'b1;
                                    f_in_data_r  <= {rx_r[6:0], tdi_s};
                                    got_r        <= got_r + 9'h001;
                                end
                            end
                        end else if (pclk_rise && !pcs_s) begin
                            rx_r   <= (nl_r == 4'h8) ? pdat_s :
                                      (nl_r == 4'h4) ? {rx_r[3:0], pdat_s[3:0]} :
                                      (nl_r == 4'h2) ? {rx_r[5:0], pdat_s[1:0]} :
                                      {rx_r[6:0], pdat_s[0]};
                            rx_n_r <= (rx_step == 4'h8) ? 4'h0 : rx_step;
                            if (rx_step == 4'h8) begin
                                f_in_valid_r <= 1'b1;
                                f_in_data_r  <= (nl_r == 4'h8) ? pdat_s :
                                                (nl_r == 4'h4) ? {rx_r[3:0], pdat_s[3:0]} :
                                                (nl_r == 4'h2) ? {rx_r[5:0], pdat_s[1:0]} :
                                                {rx_r[6:0], pdat_s[0]};
                                got_r <= got_r + 9'h001;
                            end
                        end
                    end
                    if (got_r == LOAD_BYTES[8:0]) begin
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    spi_sck <= 1'b0;
                    if (wr_n_r == LOAD_BYTES[8:0]) begin
                        gpio_weak_pullup <= 1'b0;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
            // Config reset low aborts back to idle
            if (!creset_s) begin
                state_r   <= S_IDLE;
                spi_cs_n  <= 1'b1;
                spi_sck   <= 1'b0;
                spi_dq_oe <= 4'h0;
                gpio_weak_pullup <= 1'b1;
            end
        end
    end

    // Cell memory writer and completion
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_we    <= 1'b0;
            cfg_addr  <= 8'h00;
            cfg_wdata <= 8'h00;
            wr_n_r    <= 9'h000;
            cfg_done  <= 1'b0;
            user_mode <= 1'b0;
        end else if (!creset_s) begin
            cfg_we    <= 1'b0;
            wr_n_r    <= 9'h000;
            cfg_done  <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            cfg_we <= f_out_valid;
            if (f_out_valid) begin
                cfg_addr  <= wr_n_r[7:0];
                cfg_wdata <= f_out_data;
                wr_n_r    <= wr_n_r + 9'h001;
            end
            if (wr_n_r == LOAD_BYTES[8:0] && state_r == S_DONE) begin
                cfg_done  <= 1'b1;
                user_mode <= 1'b1;
            end
        end
    end
endmodule // scl_loader
`default_nettype wire

// file: design/scl_consts.vh
/*
 * Constants for the serial configuration loader: modes, flash commands,
 * timing counts and FIFO sizing.
 * Assumes inclusion by bare name from design files under design/.
 */
`ifndef SCL_CONSTS_VH
`define SCL_CONSTS_VH

// Configuration source select
`define SCL_MODE_ACTIVE    2'h0
`define SCL_MODE_PASSIVE   2'h1
`define SCL_MODE_JTAG      2'h2
`define SCL_MODE_MASK      2'h3

// Bus width codes: 1, 2, 4 or 8 lanes
`define SCL_W_X1           2'h0
`define SCL_W_X2           2'h1
`define SCL_W_X4           2'h2
`define SCL_W_X8           2'h3

// Flash commands and start address
`define SCL_CMD_WAKE       8'hAB
`define SCL_CMD_FREAD      8'h0B
`define SCL_START_ADDR     24'h00_0000

// Clock rate and wake delay
`define SCL_MCLK_MHZ       250
`define SCL_WAKE_US        30
`define SCL_WAKE_CYC       (`SCL_WAKE_US * `SCL_MCLK_MHZ)

// Serial clock divider: half period in mclk cycles
`define SCL_SCK_HALF       4'h4

// Frame lengths in bits on a single lane
`define SCL_WAKE_BITS      6'h08
`define SCL_HDR_BITS       6'h28

// Config memory sizing and FIFO
`define SCL_CFG_AW         8
`define SCL_CFG_DEPTH      256
`define SCL_FIFO_W         8
`define SCL_FIFO_D         32
`define SCL_FIFO_AW        5

`endif

// file: design/scl_fifo.v
/*
 * Byte FIFO between the bitstream source and configuration memory.
 * Assumes a single clock and that both sides obey valid/ready.
 */
`default_nettype none
module scl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             rst_n,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    // Handshake qualifiers
    assign in_ready  = (count_r != DEPTH);
    assign out_valid = (count_r != 0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // scl_fifo
`default_nettype wire

// file: sim/scl_loader_assertions.sv
/* Checker for the configuration loader: framing, wake gap, writes, done.
   Assumes binding to scl_loader. */
`default_nettype none
module scl_loader_chk #(
    parameter int WAKE_CYC   = 20,
    parameter int LOAD_BYTES = 4
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Control and status
    input wire logic       config_reset_n,
    input wire logic       cfg_done,
    input wire logic       user_mode,
    input wire logic       gpio_weak_pullup,
    // Serial flash side
    input wire logic       spi_sck,
    input wire logic       spi_cs_n,
    input wire logic [3:0] spi_dq_out,
    // Cell memory side
    input wire logic       cfg_we,
    input wire logic [7:0] cfg_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic        sck_q;
    logic        cs_q;
    logic [1:0]  frm_r;
    logic [5:0]  bits_r;
    logic [39:0] sh_r;
    int          hi_r;
    int          wr_r;
    // Frames, bits out, idle time, writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q  <= 1'b0;
            cs_q   <= 1'b1;
            frm_r  <= 2'h0;
            bits_r <= 6'h00;
            sh_r   <= 40'h00_0000_0000;
            hi_r   <= 0;
            wr_r   <= 0;
        end else begin
            sck_q <= spi_sck;
            cs_q  <= spi_cs_n;
            hi_r  <= spi_cs_n ? hi_r + 1 : 0;
            wr_r  <= !config_reset_n ? 0 : wr_r + int'(cfg_we);
            if (!config_reset_n)
                frm_r <= 2'h0;
            else if (cs_q && !spi_cs_n && frm_r != 2'h3)
                frm_r <= frm_r + 2'h1;
            if (cs_q && !spi_cs_n)
                bits_r <= 6'h00;
            else if (!spi_cs_n && spi_sck && !sck_q && bits_r != 6'h3F) begin
                bits_r <= bits_r + 6'h01;
                sh_r   <= {sh_r[38:0], spi_dq_out[0]};
            end
        end
    end
    chk_pullup_done: assert property (gpio_weak_pullup != cfg_done)
        else $error("pull-up not the inverse of done");
    chk_user_done: assert property (user_mode == cfg_done)
        else $error("user mode differs from done");
    chk_no_write_done: assert property (cfg_done |-> !cfg_we)
        else $error("cell write after done");
    chk_addr_order: assert property (cfg_we |-> cfg_addr == wr_r[7:0])
        else $error("cell write address out of sequence");
    chk_done_count: assert property ($rose(cfg_done) |-> wr_r + int'(cfg_we) == LOAD_BYTES)
        else $error("done with wrong write count");
    chk_done_stands: assert property ($fell(cfg_done) |-> !$past(config_reset_n) ||
        !$past(config_reset_n, 2) || !$past(config_reset_n, 3) || !$past(config_reset_n, 4))
        else $error("done dropped without reset");
    chk_sck_idle: assert property (cs_q && spi_cs_n |-> !spi_sck)
        else $error("serial clock runs outside a frame");
    chk_sck_half: assert property ($rose(spi_sck) |-> spi_sck [*4])
        else $error("serial clock high phase too short");
    chk_wake_code: assert property ($rose(spi_cs_n) && frm_r == 2'h1 |->
        bits_r == 6'h08 && sh_r[7:0] == 8'hAB)
        else $error("first frame is not the wake opcode");
    chk_wake_gap: assert property ($fell(spi_cs_n) && frm_r == 2'h1 |-> hi_r >= WAKE_CYC)
        else $error("read started too soon after wake");
    chk_read_hdr: assert property (frm_r == 2'h2 && bits_r == 6'h28 |->
        sh_r == 40'h0B_0000_0000)
        else $error("read header not fast read from zero");
    cov_header: cover property (frm_r == 2'h2 && bits_r == 6'h28);
    cov_done: cover property ($rose(cfg_done));
    cov_last_write: cover property (cfg_we && cfg_addr == 8'(LOAD_BYTES - 1));
endmodule // scl_loader_chk
bind scl_loader scl_loader_chk #(.WAKE_CYC(WAKE_CYC), .LOAD_BYTES(LOAD_BYTES))
    i_scl_loader_chk (.*);
`default_nettype wire

// file: sim/scl_flash_model.sv
/* Serial flash model: wakes, then streams bytes from BASE after a fast read.
   Assumes sampling on clock rise. */
`default_nettype none
module scl_flash_model #(
    parameter logic [7:0] BASE = 8'h96
) (
    // Serial link
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic [3:0] dq_out,
    // Lane count code
    input  wire logic [1:0] width,
    // Data back to the loader
    output var  logic [3:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int         nbit = 0;
    int         bpos = 0;
    int         lanes;
    logic [7:0] cmd = 8'h00;
    logic [7:0] idx = 8'h00;
    logic [7:0] v;
    logic       awake = 1'b0;
    initial dq_in = 4'h0;
    // New frame restarts the counts
    always @(negedge cs_n) begin
        nbit = 0;
        bpos = 0;
        idx = 8'h00;
    end
    // Released lines have no pull, so show the inverse of the last value
    always @(posedge cs_n) dq_in = ~dq_in;
    // Opcode capture; the wake opcode brings the part out of power-down
    always @(posedge sck) begin
        if (!cs_n) begin
            if (nbit < 8) cmd = {cmd[6:0], dq_out[0]};
            nbit++;
            if (nbit == 8 && cmd == 8'hAB) awake = 1'b1;
        end
    end
    // Answer a fast read only when awake; high lanes carry the earlier bits
    always @(negedge sck) begin
        if (!cs_n && awake && nbit >= 48 && cmd == 8'h0B) begin
            lanes = (width == 2'h0) ? 1 : (width == 2'h1) ? 2 : 4;
            v = (BASE + idx) << bpos;
            v = v >> (8 - lanes);
            dq_in = (lanes == 1) ? {4{v[0]}} : v[3:0];
            bpos += lanes;
            if (bpos == 8) begin
                bpos = 0;
                idx++;
            end
        end
    end
endmodule // scl_flash_model
`default_nettype wire

// file: sim/scl_loader_test.sv
/* Testbench for the configuration loader: every source, widths x1, x4 and x8.
   Assumes the flash model; mask data is address xor 5A. */
`default_nettype none
module scl_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NB = 4;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       config_reset_n = 1'b0;
    logic [1:0] cfg_mode = 2'h0;
    logic [1:0] cfg_width = 2'h0;
    logic       mask_memory_option = 1'b0;
    logic       pas_clk = 1'b0;
    logic       pas_cs_n = 1'b1;
    logic [7:0] pas_data = 8'h00;
    logic       tck = 1'b0;
    logic       tdi = 1'b0;
    logic       jtag_load_en = 1'b0;
    logic       cfg_done, user_mode, gpio_weak_pullup, spi_sck, spi_cs_n, cfg_we;
    logic [3:0] spi_dq_out, spi_dq_oe, spi_dq_in;
    logic [7:0] mask_addr, mask_data, cfg_addr, cfg_wdata;
    logic [7:0] got[$];
    int         fail_count = 0;
    int         num_checks = 0;
    int         cyc = 0;
    int         cs_falls = 0;
    // Clock, mask contents and write capture
    always #2 mclk = ~mclk;
    assign mask_data = mask_addr ^ 8'h5A;
    always @(negedge spi_cs_n) cs_falls++;
    always @(posedge mclk) if (cfg_we === 1'b1) got.push_back(cfg_wdata);
    scl_loader #(.WAKE_CYC(20), .LOAD_BYTES(NB)) i_scl_loader (.*);
    scl_flash_model i_scl_flash_model (
        .sck(spi_sck), .cs_n(spi_cs_n), .dq_out(spi_dq_out), .width(cfg_width), .dq_in(spi_dq_in));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Pull the configuration reset low, then release it to start one load
    task automatic start(input logic [1:0] m, input logic [1:0] w);
        @(negedge mclk);
        config_reset_n = 1'b0;
        repeat (6) @(negedge mclk);
        check("cfg_done", 8'h00, {7'h00, cfg_done});
        check("gpio_weak_pullup", 8'h01, {7'h00, gpio_weak_pullup});
        got.delete();
        cfg_mode = m;
        cfg_width = w;
        config_reset_n = 1'b1;
    endtask
    // Wait for done, then compare every written byte
    task automatic finish_load(input logic [7:0] base, input bit xr);
        for (int i = 0; i < 4000 && cfg_done !== 1'b1; i++) @(negedge mclk);
        check("cfg_done", 8'h01, {7'h00, cfg_done});
        check("user_mode", 8'h01, {7'h00, user_mode});
        check("write count", 8'(NB), 8'(got.size()));
        for (int i = 0; i < got.size(); i++)
            check("cfg_wdata", xr ? base ^ 8'(i) : base + 8'(i), got[i]);
    endtask
    // One link clock period of 160 ns on the passive or test clock
    task automatic beat(input bit j);
        repeat (20) @(negedge mclk);
        if (j) tck = 1'b1;
        else pas_clk = 1'b1;
        repeat (20) @(negedge mclk);
        if (j) tck = 1'b0;
        else pas_clk = 1'b0;
    endtask
    task automatic active_loads();
        start(2'h0, 2'h0);
        finish_load(8'h96, 1'b0);
        start(2'h0, 2'h2);
        finish_load(8'h96, 1'b0);
    endtask
    task automatic passive_x8();
        start(2'h1, 2'h3);
        pas_cs_n = 1'b0;
        for (int i = 0; i < NB; i++) begin
            pas_data = 8'h3C + 8'(i);
            beat(1'b0);
        end
        pas_cs_n = 1'b1;
        pas_data = ~pas_data;
        finish_load(8'h3C, 1'b0);
    endtask
    task automatic jtag_x1();
        start(2'h2, 2'h0);
        jtag_load_en = 1'b1;
        for (int i = 0; i < NB * 8; i++) begin
            tdi = 1'(8'(8'h81 + 8'(i / 8)) >> (7 - i % 8));
            beat(1'b1);
        end
        jtag_load_en = 1'b0;
        tdi = ~tdi;
        finish_load(8'h81, 1'b0);
    endtask
    // Mask mode and the mask strap over active mode; the flash stays unselected
    task automatic mask_loads();
        int c0;
        c0 = cs_falls;
        start(2'h3, 2'h0);
        finish_load(8'h5A, 1'b1);
        mask_memory_option = 1'b1;
        start(2'h0, 2'h0);
        finish_load(8'h5A, 1'b1);
        check("flash selects", 8'(c0), 8'(cs_falls));
        mask_memory_option = 1'b0;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        active_loads();
        passive_x8();
        jtag_x1();
        mask_loads();
        end_of_test();
    end
endmodule // scl_loader_test
`default_nettype wire
